// ===== dmactl_pkg.sv
package dmactl_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W = 15;
    localparam int NB_W = 32;
    localparam int FIFO_DEPTH = 16;
    // ----------------------------------------------------------------
    // descriptor layout: eight 32-bit words, 32-byte aligned
    // ----------------------------------------------------------------
    localparam int DESC_WORDS = 8;
    localparam logic [2:0] DW_SADDR = 3'h0;
    localparam logic [2:0] DW_SOFF = 3'h1;
    localparam logic [2:0] DW_MINOR_BYTE_COUNT = 3'h2;
    localparam logic [2:0] DW_SLAST = 3'h3;
    localparam logic [2:0] DW_DADDR = 3'h4;
    localparam logic [2:0] DW_DOFF = 3'h5;
    localparam logic [2:0] DW_DLAST_SGA = 3'h6;
    localparam logic [2:0] DW_CSR = 3'h7;
    localparam logic [4:0] DESC_ALIGN_MASK = 5'h1f;
    // word 1: [15:0] source offset, [31:16] destination offset
    // word 5: [2:0] src size code, [5:3] dst size code, [30:16] current_iteration_count/beginning_iteration_count
    localparam int SZ_SRC_LSB = 0;
    localparam int SZ_DST_LSB = 3;
    localparam int ITER_LSB = 16;
    // csr word bits
    localparam int CSR_INT_MAJOR = 0;
    localparam int CSR_INT_HALF = 1;
    localparam int CSR_AUTO_STOP = 2;
    localparam int CSR_SG_EN = 3;
    localparam int CSR_START = 4;
    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    localparam int ST_W = 3;
    localparam int ST_DONE = 0;
    localparam int ST_ERROR = 1;
    localparam int ST_INT = 2;
    // ----------------------------------------------------------------
    // error word bits
    // ----------------------------------------------------------------
    localparam int ERR_W = 8;
    localparam int ERR_DBE = 0;
    localparam int ERR_SBE = 1;
    localparam int ERR_SGE = 2;
    localparam int ERR_NCE = 3;
    localparam int ERR_DOE = 4;
    localparam int ERR_DAE = 5;
    localparam int ERR_SOE = 6;
    localparam int ERR_SAE = 7;
    localparam logic [2:0] SIZE_MAX = 3'h5;
    localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
endpackage

// ===== dmactl_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module dmactl_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic flush, // drop contents
    input wire logic in_valid, // write offered
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word waiting
    input wire logic out_ready, // drain accepts
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic do_wr;
    logic do_rd;

    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_reg - rd_reg) <= (AW+1)'(DEPTH))
        else $error("fifo occupancy above depth");
endmodule
`default_nettype wire

// ===== dmactl_channel.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - auto-stop in descriptor makes hardware clear the request enable itself
// - descriptor holds interrupt enables, set or cleared by mask
// - at major completion add signed last adjustments to source and, without scatter-gather, destination
// - request enable set/cleared by software gates peripheral requests
// - software start performs one minor loop without a hardware request
// - current iteration count readable as major iterations not yet done
// - minor byte count reads back the live decrementing value while active
// - status flags readable, cleared by a masked clear write
// - error status word reports detected errors as a bit mask
// - scatter-gather fetches next descriptor from memory and reloads channel
// - source address not aligned to source size flags a source address error
// - each request moves minor byte count; iteration count sets request total
// - done flag set when current iteration count is exhausted
// - next descriptor address not 32-byte aligned raises scatter-gather error
// - at major completion reload current from beginning iteration count
module dmactl_channel (
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic req_pin, // peripheral request, async
    input wire logic req_en_set, // software sets request enable
    input wire logic req_en_clr, // software clears request enable
    input wire logic sw_start, // software start pulse
    input wire logic [dmactl_pkg::ST_W-1:0] status_clr, // masked flag clear
    input wire logic [1:0] int_en_set, // descriptor interrupt enables to set
    input wire logic [1:0] int_en_clr, // descriptor interrupt enables to clear
    input wire logic desc_we, // software descriptor word write
    input wire logic [2:0] desc_widx, // descriptor word index
    input wire logic [dmactl_pkg::DATA_W-1:0] desc_wdata, // descriptor word
    output logic bus_req, // bus read/write request
    output logic bus_we, // bus write
    output logic [dmactl_pkg::ADDR_W-1:0] bus_addr, // bus address
    output logic [dmactl_pkg::DATA_W-1:0] bus_wdata, // bus write data
    input wire logic bus_ack, // bus accepted / read data valid
    input wire logic bus_err, // bus error on the access
    input wire logic [dmactl_pkg::DATA_W-1:0] bus_rdata, // bus read data
    output logic req_en, // request enable
    output logic active, // channel busy
    output logic [dmactl_pkg::CNT_W-1:0] current_iteration_count_rd, // iterations remaining
    output logic [dmactl_pkg::NB_W-1:0] minor_byte_count_rd, // live minor byte count
    output logic [dmactl_pkg::ST_W-1:0] status, // done/error/int flags
    output logic [dmactl_pkg::ERR_W-1:0] err_status, // error mask
    output logic irq // channel interrupt
);
    // ----------------------------------------------------------------
    // types and storage
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_READ = 6'h02,
        S_WRITE = 6'h04,
        S_MAJOR = 6'h08,
        S_SG = 6'h10,
        S_ERR = 6'h20
    } dmactl_state_e;

    logic [dmactl_pkg::DATA_W-1:0] desc_reg [dmactl_pkg::DESC_WORDS];
    dmactl_state_e state_reg;
    logic req_s1_reg, req_s2_reg;
    logic req_en_reg, active_reg, irq_reg;
    logic [dmactl_pkg::NB_W-1:0] nb_reg;
    logic [dmactl_pkg::CNT_W-1:0] current_iteration_count_reg;
    logic [dmactl_pkg::ADDR_W-1:0] src_reg, dst_reg;
    logic [dmactl_pkg::ST_W-1:0] st_reg;
    logic [dmactl_pkg::ERR_W-1:0] err_reg;
    logic [2:0] sg_idx_reg;
    logic rd_pend_reg;
    logic fifo_in_ready, fifo_out_valid;
    logic [dmactl_pkg::DATA_W-1:0] fifo_out_data;
    logic fifo_push, fifo_pop, fifo_flush;

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    // low address bits that must be zero for a size code
    function automatic logic [4:0] size_mask(input logic [2:0] code);
        size_mask = (code > dmactl_pkg::SIZE_MAX) ? 5'h1f
            : (5'h1f >> (dmactl_pkg::SIZE_MAX - code));
    endfunction

    function automatic logic [dmactl_pkg::NB_W-1:0] size_bytes(input logic [2:0] code);
        size_bytes = dmactl_pkg::NB_W'(1) << code;
    endfunction

    logic [dmactl_pkg::DATA_W-1:0] csr, cfg;
    logic [2:0] ssz, dsz;
    logic [dmactl_pkg::CNT_W-1:0] beginning_iteration_count;
    logic [dmactl_pkg::ADDR_W-1:0] src_off, dst_off, sga;
    logic [dmactl_pkg::NB_W-1:0] step;
    logic hw_go, go, last_beat, last_iter;
    logic [dmactl_pkg::ERR_W-1:0] cfg_err;
    logic csr_wr;

    assign csr = desc_reg[dmactl_pkg::DW_CSR];
    assign cfg = desc_reg[dmactl_pkg::DW_DOFF];
    assign ssz = cfg[dmactl_pkg::SZ_SRC_LSB +: 3];
    assign dsz = cfg[dmactl_pkg::SZ_DST_LSB +: 3];
    assign beginning_iteration_count = cfg[dmactl_pkg::ITER_LSB +: dmactl_pkg::CNT_W];
    assign src_off = {{16{desc_reg[dmactl_pkg::DW_SOFF][15]}}, desc_reg[dmactl_pkg::DW_SOFF][15:0]};
    assign dst_off = {{16{desc_reg[dmactl_pkg::DW_SOFF][31]}}, desc_reg[dmactl_pkg::DW_SOFF][31:16]};
    assign sga = desc_reg[dmactl_pkg::DW_DLAST_SGA];
    // a beat moves the wider of the two sizes worth of bytes
    assign step = size_bytes((ssz > dsz) ? ssz : dsz);
    assign last_beat = nb_reg <= step;
    assign last_iter = current_iteration_count_reg <= dmactl_pkg::CNT_W'(1);
    assign hw_go = req_s2_reg && req_en_reg;
    assign go = hw_go || sw_start || csr[dmactl_pkg::CSR_START];
    assign csr_wr = desc_we && state_reg == S_IDLE && desc_widx == dmactl_pkg::DW_CSR;

    // checks run before a minor loop starts
    always_comb begin
        cfg_err = '0;
        cfg_err[dmactl_pkg::ERR_SAE] = |(src_reg[4:0] & size_mask(ssz));
        cfg_err[dmactl_pkg::ERR_DAE] = |(dst_reg[4:0] & size_mask(dsz));
        cfg_err[dmactl_pkg::ERR_SOE] = |(src_off[4:0] & size_mask(ssz));
        cfg_err[dmactl_pkg::ERR_DOE] = |(dst_off[4:0] & size_mask(dsz));
        cfg_err[dmactl_pkg::ERR_NCE] = (desc_reg[dmactl_pkg::DW_MINOR_BYTE_COUNT] == '0)
            || (current_iteration_count_reg == '0) || (ssz > dmactl_pkg::SIZE_MAX);
        cfg_err[dmactl_pkg::ERR_SGE] = csr[dmactl_pkg::CSR_SG_EN]
            && (|(sga[4:0] & dmactl_pkg::DESC_ALIGN_MASK));
    end

    // ----------------------------------------------------------------
    // request synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end else begin
            req_s1_reg <= req_pin;
            req_s2_reg <= req_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // data buffer between read and write beats
    // ----------------------------------------------------------------
    assign fifo_push = (state_reg == S_READ) && rd_pend_reg && bus_ack && !bus_err;
    assign fifo_pop = (state_reg == S_WRITE) && bus_ack;
    assign fifo_flush = (state_reg == S_ERR);

    dmactl_fifo #(.WIDTH(dmactl_pkg::DATA_W), .DEPTH(dmactl_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(bus_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // engine state
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            rd_pend_reg <= 1'b0;
            sg_idx_reg <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (go && !st_reg[dmactl_pkg::ST_ERROR]) begin
                        state_reg <= (|cfg_err) ? S_ERR : S_READ;
                    end
                end
                S_READ: begin
                    if (bus_ack && bus_err) begin
                        state_reg <= S_ERR;
                    end else if (bus_ack) begin
                        state_reg <= S_WRITE;
                    end
                    rd_pend_reg <= fifo_in_ready;
                end
                S_WRITE: begin
                    if (bus_ack && bus_err) begin
                        state_reg <= S_ERR;
                    end else if (bus_ack) begin
                        state_reg <= last_beat ? (last_iter ? S_MAJOR : S_IDLE) : S_READ;
                    end
                end
                S_MAJOR: begin
                    state_reg <= csr[dmactl_pkg::CSR_SG_EN] ? S_SG : S_IDLE;
                    sg_idx_reg <= '0;
                end
                S_SG: begin
                    if (bus_ack && bus_err) begin
                        state_reg <= S_ERR;
                    end else if (bus_ack) begin
                        sg_idx_reg <= sg_idx_reg + 3'h1;
                        if (sg_idx_reg == 3'h7) begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_ERR: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // descriptor store: software writes, scatter-gather reload
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dmactl_pkg::DESC_WORDS; i++) begin
                desc_reg[i] <= '0;
            end
        end else if (state_reg == S_SG && bus_ack && !bus_err) begin
            desc_reg[sg_idx_reg] <= bus_rdata;
        end else begin
            if (desc_we && state_reg == S_IDLE) begin
                desc_reg[desc_widx] <= desc_wdata;
            end
            // start bit self-clears once the minor loop is under way
            if (state_reg == S_IDLE && go) begin
                desc_reg[dmactl_pkg::DW_CSR][dmactl_pkg::CSR_START] <= 1'b0;
            end
            // a csr write brings its own enables; the masks still apply on top
            desc_reg[dmactl_pkg::DW_CSR][1:0] <=
                ((csr_wr ? desc_wdata[1:0] : desc_reg[dmactl_pkg::DW_CSR][1:0]) | int_en_set)
                & ~int_en_clr;
        end
    end

    // ----------------------------------------------------------------
    // addresses and counts
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= '0;
            dst_reg <= '0;
            nb_reg <= '0;
            current_iteration_count_reg <= '0;
        end else if (state_reg == S_SG || (desc_we && state_reg == S_IDLE)) begin
            // working copies follow the descriptor when it is (re)loaded
            src_reg <= desc_reg[dmactl_pkg::DW_SADDR];
            dst_reg <= desc_reg[dmactl_pkg::DW_DADDR];
            nb_reg <= desc_reg[dmactl_pkg::DW_MINOR_BYTE_COUNT];
            current_iteration_count_reg <= beginning_iteration_count;
        end else begin
            if (state_reg == S_READ && bus_ack && !bus_err) begin
                src_reg <= src_reg + src_off;
            end
            if (state_reg == S_WRITE && bus_ack && !bus_err) begin
                dst_reg <= dst_reg + dst_off;
                nb_reg <= last_beat ? desc_reg[dmactl_pkg::DW_MINOR_BYTE_COUNT] : nb_reg - step;
                if (last_beat) begin
                    current_iteration_count_reg <= last_iter ? beginning_iteration_count : current_iteration_count_reg - 1'b1;
                end
            end
            if (state_reg == S_MAJOR) begin
                src_reg <= src_reg + desc_reg[dmactl_pkg::DW_SLAST];
                dst_reg <= dst_reg + (csr[dmactl_pkg::CSR_SG_EN] ? '0 : sga);
            end
        end
    end

    // ----------------------------------------------------------------
    // enable, flags, errors
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_en_reg <= 1'b0;
        end else if (state_reg == S_WRITE && bus_ack && !bus_err && last_beat && last_iter
            && csr[dmactl_pkg::CSR_AUTO_STOP]) begin
            req_en_reg <= 1'b0;
        end else if (req_en_set) begin
            req_en_reg <= 1'b1;
        end else if (req_en_clr) begin
            req_en_reg <= 1'b0;
        end
    end

    logic major_done, half_done, err_ev;
    assign major_done = state_reg == S_WRITE && bus_ack && !bus_err && last_beat && last_iter;
    assign half_done = state_reg == S_WRITE && bus_ack && !bus_err && last_beat
        && (current_iteration_count_reg == (beginning_iteration_count >> 1) + dmactl_pkg::CNT_W'(1)) && (beginning_iteration_count > 1);
    assign err_ev = state_reg == S_ERR;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            // a flag set in the same cycle as its clear survives
            st_reg <= (st_reg & ~status_clr) | {
                (major_done && csr[dmactl_pkg::CSR_INT_MAJOR])
                    || (half_done && csr[dmactl_pkg::CSR_INT_HALF]) || err_ev,
                err_ev,
                major_done};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= dmactl_pkg::ERR_RESET;
        end else if (state_reg == S_IDLE && go && |cfg_err) begin
            err_reg <= cfg_err;
        end else if ((state_reg == S_READ || state_reg == S_SG) && bus_ack && bus_err) begin
            err_reg <= dmactl_pkg::ERR_W'(1) << dmactl_pkg::ERR_SBE;
        end else if (state_reg == S_WRITE && bus_ack && bus_err) begin
            err_reg <= dmactl_pkg::ERR_W'(1) << dmactl_pkg::ERR_DBE;
        end else if (status_clr[dmactl_pkg::ST_ERROR]) begin
            err_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            irq_reg <= 1'b0;
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            bus_addr <= '0;
            bus_wdata <= '0;
        end else begin
            active_reg <= state_reg != S_IDLE;
            irq_reg <= st_reg[dmactl_pkg::ST_INT];
            bus_req <= (state_reg == S_READ && fifo_in_ready && !bus_ack)
                || (state_reg == S_WRITE && fifo_out_valid && !bus_ack)
                || (state_reg == S_SG && !bus_ack);
            bus_we <= state_reg == S_WRITE;
            bus_addr <= (state_reg == S_SG) ? (sga + {27'h0, sg_idx_reg, 2'h0})
                : ((state_reg == S_WRITE) ? dst_reg : src_reg);
            bus_wdata <= fifo_out_data;
        end
    end

    assign req_en = req_en_reg;
    assign active = active_reg;
    assign current_iteration_count_rd = current_iteration_count_reg;
    assign minor_byte_count_rd = nb_reg;
    assign status = st_reg;
    assign err_status = err_reg;
    assign irq = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence major_end_s;
        major_done && csr[dmactl_pkg::CSR_AUTO_STOP];
    endsequence

    AST_AUTO_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        major_end_s |=> !req_en_reg && st_reg[dmactl_pkg::ST_DONE])
        else $error("auto stop did not clear request enable");
    AST_DONE_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        major_done |=> st_reg[dmactl_pkg::ST_DONE])
        else $error("done not set at major end");
    AST_CURRENT_ITERATION_COUNT_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        major_done |=> current_iteration_count_reg == $past(beginning_iteration_count))
        else $error("iteration count not reloaded");
    AST_NO_HW_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == S_IDLE && !req_en_reg && !sw_start && !csr[dmactl_pkg::CSR_START]
        |=> state_reg == S_IDLE)
        else $error("start without enable");
    AST_SW_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == S_IDLE && sw_start && !st_reg[dmactl_pkg::ST_ERROR]
        |=> state_reg == S_READ || state_reg == S_ERR)
        else $error("software start ignored");
    AST_SAE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == S_IDLE && go && !st_reg[dmactl_pkg::ST_ERROR]
        && ssz == 3'h2 && src_reg[1:0] != 2'h0
        |=> err_reg[dmactl_pkg::ERR_SAE] ##1 st_reg[dmactl_pkg::ST_ERROR])
        else $error("source address error missed");
    AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        status_clr[dmactl_pkg::ST_DONE] && !major_done |=> !st_reg[dmactl_pkg::ST_DONE])
        else $error("done flag not cleared");
    AST_NB_DEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == S_WRITE && bus_ack && !bus_err && !last_beat
        |=> nb_reg == $past(nb_reg) - $past(step))
        else $error("byte count not decrementing");
    AST_SLAST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == S_MAJOR |=> src_reg == $past(src_reg) + $past(desc_reg[3]))
        else $error("source adjustment missing");
endmodule
`default_nettype wire

// ===== dmactl_mem.sv
`timescale 1ns/10ps
`default_nettype none
module dmactl_mem (
    input wire logic ref_clk, // clock
    input wire logic bus_req, // access request
    input wire logic bus_we, // write access
    input wire logic [31:0] bus_addr, // address
    input wire logic [31:0] bus_wdata, // write data
    input wire logic [31:0] key, // read data pattern
    input wire logic slow, // one wait cycle per access
    output logic bus_ack, // access answered
    output logic [31:0] bus_rdata // read data, valid with ack
);
    logic wait_reg = 1'b0;
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic ack_reg = 1'b0;
    logic [31:0] rdata_reg = 32'h0;
    assign bus_ack = ack_reg;
    assign bus_rdata = rdata_reg;
    always @(posedge ref_clk) begin
        wait_reg <= slow & ~wait_reg & bus_req & ~bus_ack;
        ack_reg <= bus_req & ~bus_ack & ~(slow & ~wait_reg);
        // stale read data is inverted so a late sample cannot pass
        rdata_reg <= (bus_req & ~bus_ack) ? bus_addr ^ key : ~rdata_reg;
        if (bus_req & bus_ack & bus_we) begin
            wa.push_back(bus_addr);
            wd.push_back(bus_wdata);
        end
    end
endmodule
`default_nettype wire

// ===== dma_channel_transfer_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dma_channel_transfer_control_bench;
    logic ref_clk = 0, rst_n = 0, req_pin = 0, req_en_set = 0, req_en_clr = 0, sw_start = 0;
    logic desc_we = 0, bus_req, bus_we, bus_ack, req_en, active, irq, slow = 0;
    logic [2:0] status_clr = 0, desc_widx = 0, status;
    logic [1:0] int_en_set = 0, int_en_clr = 0;
    logic [31:0] desc_wdata = 0, bus_addr, bus_wdata, bus_rdata, key = 0, minor_byte_count_rd;
    logic [14:0] current_iteration_count_rd;
    logic [7:0] err_status;
    int bad_count = 0, samples_checked = 0, cycles = 0, exp_s, exp_d;
    dmactl_channel uut (.ref_clk(ref_clk), .rst_n(rst_n), .req_pin(req_pin),
        .req_en_set(req_en_set), .req_en_clr(req_en_clr), .sw_start(sw_start),
        .status_clr(status_clr), .int_en_set(int_en_set), .int_en_clr(int_en_clr),
        .desc_we(desc_we), .desc_widx(desc_widx), .desc_wdata(desc_wdata), .bus_req(bus_req),
        .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
        .bus_err(1'b0), .bus_rdata(bus_rdata), .req_en(req_en), .active(active),
        .current_iteration_count_rd(current_iteration_count_rd), .minor_byte_count_rd(minor_byte_count_rd), .status(status), .err_status(err_status),
        .irq(irq));
    dmactl_mem u_mem (.ref_clk(ref_clk), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .key(key), .slow(slow), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        // a hang ends the run as a failure
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ----------------------------------------------------------------
    // descriptor load, loop run, write-stream comparison
    // ----------------------------------------------------------------
    task automatic load(input logic [31:0] sa, input logic [14:0] it, input logic [31:0] sga,
        input logic [31:0] csr);
        logic [31:0] w[8];
        w = '{sa, 32'h0004_0004, 32'h8, 32'hffff_fff0, 32'h200, {1'b0, it, 16'h0012}, sga, csr};
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            desc_we <= 1'b1;
            desc_widx <= i[2:0];
            desc_wdata <= w[i];
        end
        @(posedge ref_clk);
        desc_we <= 1'b0;
        // fixed low byte keeps a fetched control word from restarting the channel
        key <= $urandom & 32'hffff_ff00 | 32'h18;
        exp_s = sa;
        exp_d = 32'h200;
    endtask
    task automatic go();
        @(posedge ref_clk);
        while (active !== 1'b1) @(posedge ref_clk);
        // drop requests once running, so exactly one minor loop is served
        {req_pin, sw_start, int_en_set} <= 4'h0;
        while (active !== 1'b0) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask
    task automatic chkw(input int n);
        for (int i = 0; i < n; i++) begin
            chk(u_mem.wa.pop_front(), exp_d);
            chk(u_mem.wd.pop_front(), exp_s ^ key);
            exp_s += 4;
            exp_d += 4;
        end
        chk(u_mem.wa.size(), 0);
    endtask
    initial begin
        void'($urandom(32'h344e1d7b));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        load(32'h100, 15'h2, 32'hffff_fff0, 32'h4);
        {req_en_set, int_en_clr} <= 3'b111;
        @(posedge ref_clk);
        {req_en_set, int_en_clr, int_en_set, sw_start} <= 6'b000111;
        go();
        chkw(2);
        chk(current_iteration_count_rd, 1);
        chk(status, 3'h4);
        req_pin <= 1'b1;
        go();
        chkw(2);
        chk(status, 3'h5);
        chk({req_en, irq, current_iteration_count_rd}, 17'h0_8002);
        exp_s -= 16;
        exp_d -= 16;
        {slow, sw_start} <= 2'b11;
        go();
        chkw(2);
        status_clr <= 3'h5;
        @(posedge ref_clk);
        status_clr <= 3'h0;
        req_pin <= 1'b1;
        repeat (12) @(posedge ref_clk);
        chk(status, 0);
        chk(u_mem.wa.size(), 0);
        req_pin <= 1'b0;
        // started by the descriptor's own start bit
        load(32'h102, 15'h1, 32'h0, 32'h10);
        go();
        chk({status[1], err_status[7]}, 2'b11);
        status_clr <= 3'h7;
        @(posedge ref_clk);
        status_clr <= 3'h0;
        load(32'h100, 15'h1, 32'h404, 32'h8);
        sw_start <= 1'b1;
        go();
        chk({status[1], err_status[2]}, 2'b11);
        status_clr <= 3'h7;
        @(posedge ref_clk);
        status_clr <= 3'h0;
        load(32'h100, 15'h1, 32'h400, 32'h8);
        sw_start <= 1'b1;
        go();
        chkw(2);
        chk(current_iteration_count_rd, key[30:16]);
        print_verdict();
    end
endmodule
`default_nettype wire
